// File: core/option_cfg.svh
`ifndef OPTION_CFG_SVH
`define OPTION_CFG_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define OFS_CLK_WDOG      12'h000
`define OFS_OSC_WAKE      12'h004
`define OFS_SETTLE        12'h008
`define OFS_RSVD          12'h00c
`define OFS_MEM_WAIT      12'h010
`define OFS_BOOT_OPT      12'h014
`define OFS_STATUS        12'h018
`define OFS_CONTROL       12'h01c

// ****************************************
// Field positions
// ****************************************
`define BIT_SLOW_ALLOW    3
`define BIT_INDEP_AUTO    2
`define BIT_WIN_AUTO      1
`define BIT_WIN_HALT      0
`define BIT_EXT_CLK       3
`define BIT_WAKE_SRC      2
`define BIT_DIV_HI        1
`define BIT_DIV_LO        0
`define BIT_WAIT          0
`define BIT_CTRL_LOAD     0

// ****************************************
// Reset values and misc constants
// ****************************************
`define OPT_RESET         8'h00
`define SETTLE_2048       8'h00
`define SETTLE_128        8'hb4
`define SETTLE_8          8'hd2
`define SETTLE_HALF       8'he1
`define CNT_2048          12'h800
`define CNT_128           12'h080
`define CNT_8             12'h008
`define CNT_HALF          12'h001
`define BOOT_VEC_A        16'h487e
`define BOOT_VEC_B        16'h487f
`define RESET_VECTOR      16'h8000
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`define NUM_OPT           6

`endif

// File: core/option_pkg.sv
package option_pkg;
    // Divider code: assumed external rate to reach 128 kHz
    typedef enum logic [1:0] {
        DIV_24MHZ,
        DIV_16MHZ,
        DIV_8MHZ,
        DIV_4MHZ
    } wake_div_e;
    // Decoded configuration handed to the rest of the chip
    typedef struct packed {
        logic       slowAllow;
        logic       indepAuto;
        logic       winAuto;
        logic       winHalt;
        logic       external_clock_input_select;
        logic       wakeSrc;
        wake_div_e  wakeDiv;
        logic [7:0] settleCode;
        logic       memWait;
        logic [7:0] bootOpt;
    } opt_s;
    typedef logic [7:0] byte_t;
endpackage

// File: core/opt_store_if.sv
`timescale 1ns/1ps
// Write and read path between top and option store
interface opt_store_if;
    logic                        wrEn;   // Write strobe
    logic [2:0]                  wrIdx;  // Byte index
    option_pkg::byte_t           wrData; // Byte to store
    logic [2:0]                  rdIdx;  // Read index
    option_pkg::byte_t           rdData; // Registered read data
    modport store (input wrEn, wrIdx, wrData, rdIdx, output rdData);
    modport user  (output wrEn, wrIdx, wrData, rdIdx, input rdData);
endinterface

// File: core/option_store.sv
`timescale 1ns/1ps
`include "option_cfg.svh"
// Non-volatile option byte image
module option_store (
    // Clock and reset
    input wire logic  sysClk,
    input wire logic  rst,
    // Access port
    opt_store_if.store port
);
    // Byte array, one word per option byte
    option_pkg::byte_t mem [`NUM_OPT];

    // ****************************************
    // Storage
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < `NUM_OPT; i++) begin : gByte
            // Bytes survive reset: they stand for non-volatile cells
            always_ff @(posedge sysClk) begin
                if (port.wrEn && port.wrIdx == 3'(i)) begin
                    mem[i] <= port.wrData;
                end
            end
        end
    endgenerate

    // Registered read, unmapped index reads zero
    always_ff @(posedge sysClk) begin
        if (rst) begin
            port.rdData <= `OPT_RESET;
        end else if (port.rdIdx < 3'(`NUM_OPT)) begin
            port.rdData <= mem[port.rdIdx];
        end else begin
            port.rdData <= `OPT_RESET;
        end
    end
endmodule // option_store

// File: core/settle_decode.sv
`timescale 1ns/1ps
`include "option_cfg.svh"
// Crystal settle code to cycle count
module settle_decode (
    // Clock and reset
    input wire logic        sysClk,
    input wire logic        rst,
    // Code in, count out
    input wire logic [7:0]  code,
    output logic [11:0]     cycles
);
    // ****************************************
    // Decode
    // ****************************************
    // settle code table
    always_ff @(posedge sysClk) begin
        if (rst) begin
            cycles <= `CNT_2048;
        end else begin
            case (code)
                `SETTLE_2048: cycles <= `CNT_2048;
                `SETTLE_128:  cycles <= `CNT_128;
                `SETTLE_8:    cycles <= `CNT_8;
                `SETTLE_HALF: cycles <= `CNT_HALF;
                // Unlisted codes take the safe longest wait
                default:      cycles <= `CNT_2048;
            endcase
        end
    end
endmodule // settle_decode

// File: core/option_byte_config_decode.sv
`timescale 1ns/1ps
`include "option_cfg.svh"
// Option byte store with AXI4-Lite access and reset-time decode
module option_byte_config_decode (
    // Clock and reset
    input wire logic         sysClk,
    input wire logic         rst,
    // AXI4-Lite write address
    input wire logic [11:0]  awaddr,
    input wire logic         awvalid,
    output logic             awready,
    // AXI4-Lite write data
    input wire logic [31:0]  wdata,
    input wire logic [3:0]   wstrb,
    input wire logic         wvalid,
    output logic             wready,
    // AXI4-Lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input wire logic         bready,
    // AXI4-Lite read address
    input wire logic [11:0]  araddr,
    input wire logic         arvalid,
    output logic             arready,
    // AXI4-Lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input wire logic         rready,
    // Chip status inputs
    input wire logic         haltEnter,
    input wire logic         windowDogActive,
    input wire logic         cpuClkAbove16,
    // Decoded settings
    output logic             slowInternalOscCpuAllow,
    output logic             indepDogAutoStart,
    output logic             windowDogAutoStart,
    output logic             haltResetReq,
    output logic             crystalDriveEnable,
    output logic             externalClockInputSelect,
    output logic             wakeupClockSourceSelect,
    output logic [1:0]       wakeupClockDivider,
    output logic [11:0]      crystalSettleCycles,
    output logic             memoryReadWait,
    output logic             bootCheckRequest,
    output logic [7:0]       bootLoaderOptionValue
);
    // ****************************************
    // Internal state
    // ****************************************
    opt_store_if store ();                  // Store access
    option_pkg::opt_s optQ;                 // Latched settings
    logic [2:0]  loadIdxQ;                  // Load walk index
    logic        loadBusyQ;                 // Load in progress
    logic        rdPendQ;                   // Data fetch cycle
    logic        loadDataQ;                 // Load data cycle
    logic [2:0]  loadDataIdxQ;              // Index being returned
    logic        haveAwQ;                   // Write address held
    logic        haveWQ;                    // Write data held
    logic [11:0] awAddrQ;                   // Held write address
    logic [7:0]  wByteQ;                    // Held low data byte
    logic        wLaneQ;                    // Low byte lane enabled
    logic [11:0] arAddrQ;                   // Held read address
    logic        rStageQ;                   // Read fetch stage
    logic        waitViolQ;                 // Wait state too low
    logic        bootDoneQ;                 // Boot check issued
    logic [11:0] settleCnt;                 // From decoder
    logic [2:0]  wrIdx;                     // Write byte index
    logic        wrHit;                     // Writable address
    logic        doWrite;                   // Both halves present

    // ****************************************
    // Address decode helpers
    // ****************************************
    // Byte index of an option register, 7 when not an option
    function automatic logic [2:0] optIndex(input logic [11:0] a);
        case (a)
            `OFS_CLK_WDOG: optIndex = 3'd0;
            `OFS_OSC_WAKE: optIndex = 3'd1;
            `OFS_SETTLE:   optIndex = 3'd2;
            `OFS_RSVD:     optIndex = 3'd3;
            `OFS_MEM_WAIT: optIndex = 3'd4;
            `OFS_BOOT_OPT: optIndex = 3'd5;
            default:       optIndex = 3'd7;
        endcase
    endfunction

    assign wrIdx   = optIndex(awAddrQ);
    // Reserved byte is not writable
    assign wrHit   = (wrIdx < 3'(`NUM_OPT)) && (wrIdx != 3'd3);
    assign doWrite = haveAwQ && haveWQ && !bvalid;

    // ****************************************
    // Sub-blocks
    // ****************************************
    option_store uStore (
        .sysClk (sysClk),
        .rst    (rst),
        .port   (store)
    );

    settle_decode uSettle (
        .sysClk (sysClk),
        .rst    (rst),
        .code   (optQ.settleCode),
        .cycles (settleCnt)
    );

    // Store write path: lane 0 carries the byte
    assign store.wrEn   = doWrite && wrHit && wLaneQ;
    assign store.wrIdx  = wrIdx;
    assign store.wrData = wByteQ;
    // Loader owns the read port while busy
    assign store.rdIdx  = loadBusyQ ? loadIdxQ : optIndex(arAddrQ);

    // ****************************************
    // Reset-time loader
    // ****************************************
    // walk bytes after reset
    always_ff @(posedge sysClk) begin
        if (rst) begin
            loadBusyQ    <= 1'b1;
            loadIdxQ     <= 3'd0;
            loadDataQ    <= 1'b0;
            loadDataIdxQ <= 3'd0;
        end else begin
            loadDataQ    <= loadBusyQ;
            loadDataIdxQ <= loadIdxQ;
            if (loadBusyQ) begin
                if (loadIdxQ == 3'(`NUM_OPT - 1)) begin
                    loadBusyQ <= 1'b0;
                end
                loadIdxQ <= loadIdxQ + 3'd1;
            end
            // No reload path: settings may only move at a reset
        end
    end

    always_ff @(posedge sysClk) begin
        if (rst) begin
            optQ <= '0;
        end else if (loadDataQ) begin
            case (loadDataIdxQ)
                3'd0: begin
                    optQ.slowAllow <= store.rdData[`BIT_SLOW_ALLOW];
                    optQ.indepAuto <= store.rdData[`BIT_INDEP_AUTO];
                    optQ.winAuto   <= store.rdData[`BIT_WIN_AUTO];
                    optQ.winHalt   <= store.rdData[`BIT_WIN_HALT];
                end
                3'd1: begin
                    optQ.external_clock_input_select  <= store.rdData[`BIT_EXT_CLK];
                    optQ.wakeSrc <= store.rdData[`BIT_WAKE_SRC];
                    optQ.wakeDiv <= option_pkg::wake_div_e'(
                        store.rdData[`BIT_DIV_HI:`BIT_DIV_LO]);
                end
                3'd2: optQ.settleCode <= store.rdData;
                3'd4: optQ.memWait    <= store.rdData[`BIT_WAIT];
                3'd5: optQ.bootOpt    <= store.rdData;
                // Reserved byte carries nothing
                default: ;
            endcase
        end
    end

    // ****************************************
    // Decoded outputs
    // ****************************************
    // Registered copies of the latched settings; drive enable inverted, settle count from decoder
    always_ff @(posedge sysClk) begin
        if (rst) begin
            slowInternalOscCpuAllow  <= 1'b0;
            indepDogAutoStart        <= 1'b0;
            windowDogAutoStart       <= 1'b0;
            crystalDriveEnable       <= 1'b0;
            externalClockInputSelect <= 1'b0;
            wakeupClockSourceSelect  <= 1'b0;
            wakeupClockDivider       <= 2'b00;
            crystalSettleCycles      <= `CNT_2048;
            memoryReadWait           <= 1'b0;
            bootLoaderOptionValue    <= `OPT_RESET;
        end else begin
            slowInternalOscCpuAllow  <= optQ.slowAllow;
            indepDogAutoStart        <= optQ.indepAuto;
            windowDogAutoStart       <= optQ.winAuto;
            crystalDriveEnable       <= !optQ.external_clock_input_select;
            externalClockInputSelect <= optQ.external_clock_input_select;
            wakeupClockSourceSelect  <= optQ.wakeSrc;
            wakeupClockDivider       <= optQ.wakeDiv;
            crystalSettleCycles      <= settleCnt;
            memoryReadWait           <= optQ.memWait;
            bootLoaderOptionValue    <= optQ.bootOpt;
        end
    end

    always_ff @(posedge sysClk) begin
        if (rst) begin
            haltResetReq <= 1'b0;
        end else begin
            haltResetReq <= haltEnter && windowDogActive && optQ.winHalt;
        end
    end

    // flag zero wait at high clock
    always_ff @(posedge sysClk) begin
        if (rst) begin
            waitViolQ <= 1'b0;
        end else begin
            waitViolQ <= cpuClkAbove16 && !optQ.memWait;
        end
    end

    // one boot check pulse after load
    always_ff @(posedge sysClk) begin
        if (rst) begin
            bootDoneQ        <= 1'b0;
            bootCheckRequest <= 1'b0;
        end else begin
            bootCheckRequest <= 1'b0;
            if (!bootDoneQ && !loadBusyQ && !loadDataQ) begin
                bootDoneQ        <= 1'b1;
                bootCheckRequest <= 1'b1;
            end
        end
    end

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    // Capture address and data in either order
    always_ff @(posedge sysClk) begin
        if (rst) begin
            haveAwQ <= 1'b0;
            awAddrQ <= 12'h000;
        end else if (awvalid && awready) begin
            haveAwQ <= 1'b1;
            awAddrQ <= awaddr;
        end else if (doWrite) begin
            haveAwQ <= 1'b0;
        end
    end

    always_ff @(posedge sysClk) begin
        if (rst) begin
            haveWQ <= 1'b0;
            wByteQ <= `OPT_RESET;
            wLaneQ <= 1'b0;
        end else if (wvalid && wready) begin
            haveWQ <= 1'b1;
            wByteQ <= wdata[7:0];
            wLaneQ <= wstrb[0];
        end else if (doWrite) begin
            haveWQ <= 1'b0;
        end
    end

    // Ready while the slot is empty and no response waits
    always_ff @(posedge sysClk) begin
        if (rst) begin
            awready <= 1'b0;
            wready  <= 1'b0;
        end else begin
            awready <= !haveAwQ && !(awvalid && awready) && !bvalid;
            wready  <= !haveWQ && !(wvalid && wready) && !bvalid;
        end
    end

    // Response; control writes are taken with OKAY but store nothing
    always_ff @(posedge sysClk) begin
        if (rst) begin
            bvalid     <= 1'b0;
            bresp      <= `RESP_OKAY;
        end else begin
            if (doWrite) begin
                bvalid <= 1'b1;
                if (wrHit) begin
                    bresp <= `RESP_OKAY;
                end else if (awAddrQ == `OFS_CONTROL) begin
                    bresp      <= `RESP_OKAY;
                end else begin
                    bresp <= `RESP_SLVERR;
                end
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    // Reads wait while the loader owns the store port
    always_ff @(posedge sysClk) begin
        if (rst) begin
            arready <= 1'b0;
            arAddrQ <= 12'h000;
            rStageQ <= 1'b0;
            rdPendQ <= 1'b0;
        end else begin
            arready <= !rStageQ && !rdPendQ && !rvalid && !arready
                       && !loadBusyQ;
            if (arvalid && arready) begin
                arAddrQ <= araddr;
                rStageQ <= 1'b1;
            end else if (rStageQ) begin
                rStageQ <= 1'b0;
                rdPendQ <= 1'b1;
            end else begin
                rdPendQ <= 1'b0;
            end
        end
    end

    always_ff @(posedge sysClk) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= `RESP_OKAY;
        end else if (rdPendQ) begin
            rvalid <= 1'b1;
            rresp  <= `RESP_OKAY;
            if (optIndex(arAddrQ) != 3'd7) begin
                // Reserved byte reads as zero
                rdata <= (optIndex(arAddrQ) == 3'd3) ? 32'h0000_0000
                         : {24'h00_0000, store.rdData};
            end else if (arAddrQ == `OFS_STATUS) begin
                rdata <= {28'h000_0000, bootDoneQ, waitViolQ,
                          optQ.winAuto, loadBusyQ};
            end else if (arAddrQ == `OFS_CONTROL) begin
                rdata <= 32'h0000_0000;
            end else begin
                rdata <= 32'h0000_0000;
                rresp <= `RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule // option_byte_config_decode

// File: test/opt_decode_asserts.sv
`timescale 1ns/1ps
// ****************************************
// Bus and decode checks
// ****************************************
module opt_decode_asserts (
    // Clock and reset
    input wire logic        sysClk,
    input wire logic        rst,
    // Bus handshakes
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    // Decoded settings
    input wire logic        haltEnter,
    input wire logic        windowDogActive,
    input wire logic        haltResetReq,
    input wire logic        slowInternalOscCpuAllow,
    input wire logic        indepDogAutoStart,
    input wire logic        windowDogAutoStart,
    input wire logic        crystalDriveEnable,
    input wire logic        externalClockInputSelect,
    input wire logic        wakeupClockSourceSelect,
    input wire logic [1:0]  wakeupClockDivider,
    input wire logic [11:0] crystalSettleCycles,
    input wire logic        memoryReadWait,
    input wire logic        bootCheckRequest,
    input wire logic [7:0]  bootLoaderOptionValue
);
    default clocking cb @(posedge sysClk); endclocking
    default disable iff (rst);
    // First load reads an unwritten image, so decode checks wait
    logic       armedQ = 1'b0;
    logic       bootSeenQ = 1'b0;  // Unwritten first load has ended
    logic [1:0] holdCntQ;   // Cycles since the load finished
    wire [28:0] cfgNow = {slowInternalOscCpuAllow, indepDogAutoStart,
        windowDogAutoStart, crystalDriveEnable, externalClockInputSelect,
        wakeupClockSourceSelect, wakeupClockDivider, crystalSettleCycles,
        memoryReadWait, bootLoaderOptionValue};
    // Arm at the first reset after the unwritten load
    always_ff @(posedge sysClk) begin
        if (bootCheckRequest) bootSeenQ <= 1'b1;
        if (rst && bootSeenQ) armedQ <= 1'b1;
    end
    // Count to the settled window
    always_ff @(posedge sysClk) begin
        if (rst) holdCntQ <= 2'd0;
        else if (bootCheckRequest) holdCntQ <= 2'd1;
        else if (holdCntQ != 2'd0 && holdCntQ != 2'd3)
            holdCntQ <= holdCntQ + 2'd1;
    end
    sequence relSeq;
        $fell(rst);
    endsequence
    sequence loadSeq;
        armedQ && bootCheckRequest ##2 1'b1;
    endsequence
    bvalid_hold_a: assert property (bvalid && !bready |=>
        bvalid && $stable(bresp)) else $error("bvalid dropped early");
    rvalid_hold_a: assert property (rvalid && !rready |=> rvalid &&
        $stable(rdata) && $stable(rresp)) else $error("rvalid dropped");
    read_answer_a: assert property (arvalid && arready |-> ##[1:8] rvalid)
        else $error("read never answered");
    halt_cause_a: assert property (haltResetReq |->
        $past(haltEnter) && $past(windowDogActive)) else $error("halt rst");
    drive_invert_a: assert property (loadSeq |->
        crystalDriveEnable != externalClockInputSelect) else $error("osc");
    settle_value_a: assert property (loadSeq |-> crystalSettleCycles
        inside {12'h800, 12'h080, 12'h008, 12'h001}) else $error("settle");
    cfg_stable_a: assert property (armedQ && holdCntQ == 2'd3 |=>
        $stable(cfgNow)) else $error("settings moved after load");
    boot_once_a: assert property (holdCntQ != 2'd0 |->
        !bootCheckRequest) else $error("second boot check");
    boot_after_rst_a: assert property (relSeq |->
        ##[1:40] bootCheckRequest) else $error("no boot check");
endmodule // opt_decode_asserts

// File: test/tb_top.sv
`timescale 1ns/1ps
`include "option_cfg.svh"
// ****************************************
// Option byte bench
// ****************************************
module tb_top;
    logic sysClk = 1'b0, rst = 1'b1;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic haltEnter = 0, windowDogActive = 0, cpuClkAbove16 = 0;
    logic awready, wready, bvalid, arready, rvalid, haltResetReq;
    logic [1:0]  bresp, rresp, wakeupClockDivider;
    logic [31:0] rdata;
    logic slowInternalOscCpuAllow, indepDogAutoStart, windowDogAutoStart;
    logic crystalDriveEnable, externalClockInputSelect, memoryReadWait;
    logic wakeupClockSourceSelect, bootCheckRequest;
    logic [11:0] crystalSettleCycles;
    logic [7:0]  bootLoaderOptionValue;
    logic [39:0] bq[$], rq[$], cq[$];   // Expected results in order
    int err_count = 0, checks_done = 0, seed;
    always #12.5 sysClk = ~sysClk;
    option_byte_config_decode dut_u (.sysClk, .rst, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .haltEnter, .windowDogActive, .cpuClkAbove16, .haltResetReq,
        .slowInternalOscCpuAllow, .indepDogAutoStart, .windowDogAutoStart,
        .crystalDriveEnable, .externalClockInputSelect,
        .wakeupClockSourceSelect, .wakeupClockDivider, .crystalSettleCycles,
        .memoryReadWait, .bootCheckRequest, .bootLoaderOptionValue);
    wire [29:0] cfgSeen = {slowInternalOscCpuAllow, indepDogAutoStart,
        windowDogAutoStart, haltResetReq, externalClockInputSelect,
        crystalDriveEnable, wakeupClockSourceSelect, wakeupClockDivider,
        crystalSettleCycles, memoryReadWait, bootLoaderOptionValue};
    // Compare one result
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic stop_test;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait for one edge with a flag high
    task automatic waitFor(ref logic f);
        int n;
        n = 0;
        do begin
            @(posedge sysClk);
            n++;
        end while (f !== 1'b1 && n < 100);
        if (n >= 100) err_count++;
    endtask
    // Bus write; address and data offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        bq.push_back({38'h0, r});
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sysClk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        if (!bvalid) waitFor(bvalid);
        bready <= 1'b0;
        @(posedge sysClk);
    endtask
    // Bus read
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        rq.push_back({6'h0, e});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        waitFor(arready);
        arvalid <= 1'b0;
        if (!rvalid) waitFor(rvalid);
        rready <= 1'b0;
        @(posedge sysClk);
    endtask
    // Settle code to cycles; unlisted codes give the longest wait
    function automatic logic [11:0] cnt(input logic [7:0] c);
        case (c)
            8'hb4: return 12'h080;
            8'hd2: return 12'h008;
            8'he1: return 12'h001;
            default: return 12'h800;
        endcase
    endfunction
    // Result monitors
    always @(posedge sysClk) begin
        if (bvalid && bready) chk(bresp, bq.pop_front());
        if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    end
    always @(posedge sysClk) begin
        if (bootCheckRequest && cq.size() > 0) begin
            repeat (2) @(posedge sysClk);
            chk(cfgSeen, cq.pop_front());
        end
    end
    // Watchdog on the whole run
    initial begin
        #(25 * 20000);
        err_count++;
        stop_test;
    end
    // Main sequence
    initial begin
        logic [7:0] b0, b1, b2, b4, b5, codes[6];
        logic h, w, c;
        seed = 75161;
        codes = '{8'h00, 8'hb4, 8'hd2, 8'he1, 8'h37, 8'hff};
        repeat (8) @(posedge sysClk);
        chk(crystalSettleCycles, 12'h800);
        rst <= 1'b0;
        waitFor(bootCheckRequest);
        rd(12'h020, {`RESP_SLVERR, 32'h0});
        wr(12'h020, 32'h1, `RESP_SLVERR);
        wr(`OFS_RSVD, 32'h5, `RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            b0 = $random(seed);
            b1 = {$random(seed)} % 256;
            b1[1:0] = i[1:0];
            b2 = codes[i];
            b4 = {7'h0, i[0]};
            b5 = $random(seed);
            {h, w, c} = $random(seed);
            cpuClkAbove16 <= c;
            wr(`OFS_CLK_WDOG, {24'h0, b0}, `RESP_OKAY);
            wr(`OFS_OSC_WAKE, {24'h0, b1}, `RESP_OKAY);
            wr(`OFS_SETTLE, {24'h0, b2}, `RESP_OKAY);
            wr(`OFS_MEM_WAIT, {24'h0, b4}, `RESP_OKAY);
            wr(`OFS_BOOT_OPT, {24'h0, b5}, `RESP_OKAY);
            rd(`OFS_CLK_WDOG, {`RESP_OKAY, 24'h0, b0});
            rd(`OFS_SETTLE, {`RESP_OKAY, 24'h0, b2});
            rd(`OFS_BOOT_OPT, {`RESP_OKAY, 24'h0, b5});
            cq.push_back({b0[3:1], h & w & b0[0], b1[3], ~b1[3], b1[2:0],
                          cnt(b2), b4[0], b5});
            haltEnter <= h;
            windowDogActive <= w;
            rst <= 1'b1;
            repeat (2) @(posedge sysClk);
            rst <= 1'b0;
            waitFor(bootCheckRequest);
            repeat (3) @(posedge sysClk);
            rd(`OFS_STATUS, {`RESP_OKAY, 28'h0, 1'b1, c & ~b4[0],
                             b0[1], 1'b0});
        end
        stop_test;
    end
endmodule // tb_top
bind option_byte_config_decode opt_decode_asserts chk_u (.sysClk, .rst,
    .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
    .rresp, .haltEnter, .windowDogActive, .haltResetReq,
    .slowInternalOscCpuAllow, .indepDogAutoStart, .windowDogAutoStart,
    .crystalDriveEnable, .externalClockInputSelect,
    .wakeupClockSourceSelect, .wakeupClockDivider, .crystalSettleCycles,
    .memoryReadWait, .bootCheckRequest, .bootLoaderOptionValue);
